/* File: rtl/uera_pkg.sv */
// Purpose: Shared constants for the extended register access block
// Assumes: 3-bit UART register address, 8-bit data
// Notes:   All reset values are zero unless named otherwise
package uera_pkg;

  // Direct addresses on the UART register bus
  localparam logic [2:0] ADDR_ADDITIONAL_STATUS = 3'h1;
  localparam logic [2:0] ADDR_ENHANCED_FEATURES = 3'h2;
  localparam logic [2:0] ADDR_LINE_CONTROL      = 3'h3;
  localparam logic [2:0] ADDR_RX_FIFO_LEVEL     = 3'h3;
  localparam logic [2:0] ADDR_RESUME_CHAR_ONE   = 3'h4;
  localparam logic [2:0] ADDR_TX_FIFO_LEVEL     = 3'h4;
  localparam logic [2:0] ADDR_RESUME_CHAR_TWO   = 3'h5;
  localparam logic [2:0] ADDR_INDEXED_WINDOW    = 3'h5;
  localparam logic [2:0] ADDR_PAUSE_CHAR_ONE    = 3'h6;
  localparam logic [2:0] ADDR_PAUSE_CHAR_TWO    = 3'h7;
  localparam logic [2:0] ADDR_SCRATCH_INDEX     = 3'h7;

  // Line control value that opens the 650-compatible bank
  localparam logic [7:0] LINE_CONTROL_BANK650   = 8'hBF;

  // Offsets inside the indexed register set
  localparam logic [7:0] IDX_ADDITIONAL_CONTROL = 8'h00;
  localparam logic [7:0] IDX_CLOCK_PRESCALER    = 8'h01;
  localparam logic [7:0] IDX_SAMPLE_CLOCK_TIMES = 8'h02;
  localparam logic [7:0] IDX_CLOCK_SELECT       = 8'h03;
  localparam logic [7:0] IDX_TX_IRQ_THRESHOLD   = 8'h04;
  localparam logic [7:0] IDX_RX_IRQ_THRESHOLD   = 8'h05;
  localparam logic [7:0] IDX_FLOW_LOW_THRESHOLD = 8'h05;

  // Field positions
  localparam int EF_CTS_FLOW_BIT     = 7;
  localparam int EF_RTS_FLOW_BIT     = 6;
  localparam int EF_SPECIAL_CHAR_BIT = 5;
  localparam int EF_ENHANCED_BIT     = 4;
  localparam int EF_INBAND_MSB       = 3;
  localparam int AC_STATUS_EN_BIT    = 7;
  localparam int AC_WINDOW_RD_BIT    = 6;
  localparam int AC_TRIGGER_EN_BIT   = 5;
  localparam int LC_DIVISOR_BIT      = 7;
  localparam int AS_WRITABLE_MSB     = 1;
  localparam int LEVEL_MSB           = 6;

  // Reset values
  localparam logic [7:0] RST_BYTE           = 8'h00;
  localparam logic [7:0] RST_RX_THRESHOLD   = 8'h01;
  localparam logic [1:0] RST_STATUS_FLAGS   = 2'h0;
  localparam logic [6:0] DEFAULT_TX_TRIGGER = 7'h00;
  localparam logic [6:0] DEFAULT_RX_TRIGGER = 7'h01;

  typedef enum logic [1:0]
  {
    UERA_BANK_NORMAL = 2'b00,
    UERA_BANK_650    = 2'b01,
    UERA_BANK_DIV    = 2'b10
  } uera_bank_t;

endpackage : uera_pkg

/* File: rtl/uera_status.sv */
// Purpose: Additional status byte with its two software-writable flags
// Assumes: Write strobe already qualified by the address decoder
// Notes:   Upper six bits mirror live datapath state
`timescale 1ns/1ps
module uera_status
  import uera_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] live_bits,
  output logic      [7:0] status_q,
  output logic      [1:0] tx_disable_q
);

  logic [1:0] flags_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      flags_q <= RST_STATUS_FLAGS;
    else if (wr_stb)
      flags_q <= wdata[AS_WRITABLE_MSB:0];
  end

  // Live bits are registered so readback never sees a mid-cycle change
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      status_q <= RST_BYTE;
    else
      status_q <= {live_bits, flags_q};
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tx_disable_q <= RST_STATUS_FLAGS;
    else
      tx_disable_q <= flags_q;
  end

endmodule : uera_status

/* File: rtl/uera_trigger.sv */
// Purpose: FIFO threshold comparison for transmit and receive interrupts
// Assumes: FIFO counts are stable for a cycle
// Notes:   Bit 7 of each threshold is ignored
`timescale 1ns/1ps
module uera_trigger
  import uera_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       enable_950,
  input  wire logic [7:0] tx_level,
  input  wire logic [7:0] rx_level,
  input  wire logic [7:0] tx_threshold,
  input  wire logic [7:0] rx_threshold,
  output logic            tx_trigger_q,
  output logic            rx_trigger_q
);

  logic [6:0] tx_limit;
  logic [6:0] rx_limit;

  // Without 950 trigger mode the levels fall back to fixed defaults
  assign tx_limit = enable_950 ? tx_threshold[LEVEL_MSB:0] : DEFAULT_TX_TRIGGER;
  assign rx_limit = enable_950 ? rx_threshold[LEVEL_MSB:0] : DEFAULT_RX_TRIGGER;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tx_trigger_q <= 1'b0;
    else
      tx_trigger_q <= (tx_level <= {1'b0, tx_limit});
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rx_trigger_q <= 1'b0;
    else
      rx_trigger_q <= (rx_level >= {1'b0, rx_limit});
  end

endmodule : uera_trigger

/* File: rtl/uera_regs.sv */
// Purpose: Extended register access for one UART channel
// Assumes: Single-cycle read and write strobes on a 3-bit address bus
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ps
module uera_regs
  import uera_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [2:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rx_count,
  input  wire logic [7:0] tx_count,
  input  wire logic [5:0] live_status,
  output logic      [7:0] rdata_q,
  output logic            rvalid_q,
  output logic      [7:0] line_control_q,
  output logic      [7:0] scratch_index_q,
  output logic      [7:0] enhanced_features_q,
  output logic            cts_flow_en_q,
  output logic            rts_flow_en_q,
  output logic            special_char_en_q,
  output logic            enhanced_mode_q,
  output logic      [3:0] inband_mode_q,
  output logic      [7:0] resume_char_one_q,
  output logic      [7:0] resume_char_two_q,
  output logic      [7:0] pause_char_one_q,
  output logic      [7:0] pause_char_two_q,
  output logic      [7:0] additional_control_q,
  output logic      [7:0] clock_prescaler_q,
  output logic      [7:0] sample_clock_times_q,
  output logic      [7:0] clock_select_q,
  output logic      [7:0] tx_irq_threshold_q,
  output logic      [7:0] rx_irq_threshold_q,
  output logic      [7:0] flow_low_threshold_q,
  output logic      [7:0] additional_status_q,
  output logic      [1:0] tx_disable_q,
  output logic            tx_trigger_q,
  output logic            rx_trigger_q
);

  uera_bank_t bank;
  logic       status_en;
  logic       window_rd_en;
  logic       wr_bank650;
  logic       wr_normal;
  logic       wr_status;
  logic       wr_window;
  logic [7:0] window_rdata;
  logic [7:0] rdata_d;

  // Bank follows the last value written to line control
  always_comb
  begin
    if (line_control_q == LINE_CONTROL_BANK650)
      bank = UERA_BANK_650;
    else if (line_control_q[LC_DIVISOR_BIT])
      bank = UERA_BANK_DIV;
    else
      bank = UERA_BANK_NORMAL;
  end

  assign status_en    = additional_control_q[AC_STATUS_EN_BIT];
  assign window_rd_en = additional_control_q[AC_WINDOW_RD_BIT];
  assign wr_bank650   = wr_en && (bank == UERA_BANK_650);
  assign wr_normal    = wr_en && (bank == UERA_BANK_NORMAL);
  assign wr_status    = wr_normal && status_en && (addr == ADDR_ADDITIONAL_STATUS);
  assign wr_window    = wr_normal && (addr == ADDR_INDEXED_WINDOW);

  // Line control is reachable from every bank so the bank can be left
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      line_control_q <= RST_BYTE;
    else if (wr_en && addr == ADDR_LINE_CONTROL)
      line_control_q <= wdata;
  end

  // Scratch index shares its address with the pause character two
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      scratch_index_q <= RST_BYTE;
    else if (wr_en && bank != UERA_BANK_650 && addr == ADDR_SCRATCH_INDEX)
      scratch_index_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      enhanced_features_q <= RST_BYTE;
    else if (wr_bank650 && addr == ADDR_ENHANCED_FEATURES)
      enhanced_features_q <= wdata;
  end

  // Each decoded field has its own flop so flow logic sees clean levels
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cts_flow_en_q <= 1'b0;
    else
      cts_flow_en_q <= enhanced_features_q[EF_CTS_FLOW_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rts_flow_en_q <= 1'b0;
    else
      rts_flow_en_q <= enhanced_features_q[EF_RTS_FLOW_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      special_char_en_q <= 1'b0;
    else
      special_char_en_q <= enhanced_features_q[EF_SPECIAL_CHAR_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      enhanced_mode_q <= 1'b0;
    else
      enhanced_mode_q <= enhanced_features_q[EF_ENHANCED_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      inband_mode_q <= 4'h0;
    else
      inband_mode_q <= enhanced_features_q[EF_INBAND_MSB:0];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      resume_char_one_q <= RST_BYTE;
    else if (wr_bank650 && addr == ADDR_RESUME_CHAR_ONE)
      resume_char_one_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      resume_char_two_q <= RST_BYTE;
    else if (wr_bank650 && addr == ADDR_RESUME_CHAR_TWO)
      resume_char_two_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pause_char_one_q <= RST_BYTE;
    else if (wr_bank650 && addr == ADDR_PAUSE_CHAR_ONE)
      pause_char_one_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pause_char_two_q <= RST_BYTE;
    else if (wr_bank650 && addr == ADDR_PAUSE_CHAR_TWO)
      pause_char_two_q <= wdata;
  end

  // Indexed control set; offsets outside the set are dropped on write
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      additional_control_q <= RST_BYTE;
    else if (wr_window && scratch_index_q == IDX_ADDITIONAL_CONTROL)
      additional_control_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      clock_prescaler_q <= RST_BYTE;
    else if (wr_window && scratch_index_q == IDX_CLOCK_PRESCALER)
      clock_prescaler_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sample_clock_times_q <= RST_BYTE;
    else if (wr_window && scratch_index_q == IDX_SAMPLE_CLOCK_TIMES)
      sample_clock_times_q <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      clock_select_q <= RST_BYTE;
    else if (wr_window && scratch_index_q == IDX_CLOCK_SELECT)
      clock_select_q <= wdata;
  end

  // Bit 7 of the transmit trigger is unused and always reads zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tx_irq_threshold_q <= RST_BYTE;
    else if (wr_window && scratch_index_q == IDX_TX_IRQ_THRESHOLD)
      tx_irq_threshold_q <= {1'b0, wdata[LEVEL_MSB:0]};
  end

  // Receive trigger and flow low level share one offset, so one write loads both
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rx_irq_threshold_q <= RST_RX_THRESHOLD;
    else if (wr_window && scratch_index_q == IDX_RX_IRQ_THRESHOLD)
      rx_irq_threshold_q <= {1'b0, wdata[LEVEL_MSB:0]};
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      flow_low_threshold_q <= RST_BYTE;
    else if (wr_window && scratch_index_q == IDX_FLOW_LOW_THRESHOLD)
      flow_low_threshold_q <= {1'b0, wdata[LEVEL_MSB:0]};
  end

  // Window readback; reserved offsets read zero so stray reads are harmless
  always_comb
  begin
    case (scratch_index_q)
      IDX_ADDITIONAL_CONTROL: window_rdata = additional_control_q;
      IDX_CLOCK_PRESCALER:    window_rdata = clock_prescaler_q;
      IDX_SAMPLE_CLOCK_TIMES: window_rdata = sample_clock_times_q;
      IDX_CLOCK_SELECT:       window_rdata = clock_select_q;
      IDX_TX_IRQ_THRESHOLD:   window_rdata = tx_irq_threshold_q;
      IDX_RX_IRQ_THRESHOLD:   window_rdata = rx_irq_threshold_q;
      default:                window_rdata = RST_BYTE;
    endcase
  end

  // Read multiplexer; base 550 registers outside this block read zero
  always_comb
  begin
    rdata_d = RST_BYTE;
    case (bank)
      UERA_BANK_650:
      begin
        case (addr)
          ADDR_ENHANCED_FEATURES: rdata_d = enhanced_features_q;
          ADDR_LINE_CONTROL:      rdata_d = line_control_q;
          ADDR_RESUME_CHAR_ONE:   rdata_d = resume_char_one_q;
          ADDR_RESUME_CHAR_TWO:   rdata_d = resume_char_two_q;
          ADDR_PAUSE_CHAR_ONE:    rdata_d = pause_char_one_q;
          ADDR_PAUSE_CHAR_TWO:    rdata_d = pause_char_two_q;
          default:                rdata_d = RST_BYTE;
        endcase
      end
      UERA_BANK_NORMAL:
      begin
        case (addr)
          ADDR_ADDITIONAL_STATUS:
            rdata_d = status_en ? additional_status_q : RST_BYTE;
          ADDR_RX_FIFO_LEVEL:
            rdata_d = status_en ? rx_count : line_control_q;
          ADDR_TX_FIFO_LEVEL:
            rdata_d = status_en ? tx_count : RST_BYTE;
          ADDR_INDEXED_WINDOW:
            rdata_d = window_rd_en ? window_rdata : RST_BYTE;
          ADDR_SCRATCH_INDEX:
            rdata_d = scratch_index_q;
          default:
            rdata_d = RST_BYTE;
        endcase
      end
      UERA_BANK_DIV:
      begin
        // Divisor bank belongs to the base set; only line control and scratch index answer
        if (addr == ADDR_LINE_CONTROL)
          rdata_d = line_control_q;
        else if (addr == ADDR_SCRATCH_INDEX)
          rdata_d = scratch_index_q;
        else
          rdata_d = RST_BYTE;
      end
      default:
        rdata_d = RST_BYTE;
    endcase
  end

  // Read data holds until the next read, so late sampling stays safe
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata_q <= RST_BYTE;
    else if (rd_en)
      rdata_q <= rdata_d;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= rd_en;
  end

  uera_status u_status
  (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .wr_stb       (wr_status),
    .wdata        (wdata),
    .live_bits    (live_status),
    .status_q     (additional_status_q),
    .tx_disable_q (tx_disable_q)
  );

  uera_trigger u_trigger
  (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .enable_950   (additional_control_q[AC_TRIGGER_EN_BIT]),
    .tx_level     (tx_count),
    .rx_level     (rx_count),
    .tx_threshold (tx_irq_threshold_q),
    .rx_threshold (rx_irq_threshold_q),
    .tx_trigger_q (tx_trigger_q),
    .rx_trigger_q (rx_trigger_q)
  );

endmodule : uera_regs

/* File: testbench/uera_regs_assertions.sv */
// Purpose: Port-level checks for the extended register access block
// Assumes: Synchronous active-high reset, one clock domain
// Notes:   Bound to uera_regs from the testbench top file
`timescale 1ns/1ps
module uera_chk
  import uera_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [2:0] addr,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rx_count,
  input wire logic [7:0] tx_count,
  input wire logic [5:0] live_status,
  input wire logic [7:0] rdata_q,
  input wire logic       rvalid_q,
  input wire logic [7:0] line_control_q,
  input wire logic [7:0] scratch_index_q,
  input wire logic [7:0] enhanced_features_q,
  input wire logic       cts_flow_en_q,
  input wire logic       rts_flow_en_q,
  input wire logic       special_char_en_q,
  input wire logic       enhanced_mode_q,
  input wire logic [3:0] inband_mode_q,
  input wire logic [7:0] additional_control_q,
  input wire logic [7:0] tx_irq_threshold_q,
  input wire logic [7:0] additional_status_q,
  input wire logic [1:0] tx_disable_q
);
  import uera_pkg::*;
  logic normal;
  // Normal bank: neither the 650 bank nor the divisor bank is open
  assign normal = (line_control_q != LINE_CONTROL_BANK650) && !line_control_q[LC_DIVISOR_BIT];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_status_wr;
    wr_en && addr == ADDR_ADDITIONAL_STATUS && normal && additional_control_q[AC_STATUS_EN_BIT];
  endsequence
  sequence s_stat_rd(logic [2:0] a);
    rd_en && addr == a && normal && additional_control_q[AC_STATUS_EN_BIT];
  endsequence

  AST_EF_DECODE: assert property (!$past(sys_rst) |-> {cts_flow_en_q, rts_flow_en_q,
    special_char_en_q, enhanced_mode_q, inband_mode_q} == $past(enhanced_features_q))
    else $error("flow decodes differ from enhanced features");
  AST_EF_ACCEPT: assert property (wr_en && addr == ADDR_ENHANCED_FEATURES &&
    line_control_q == LINE_CONTROL_BANK650 |=> enhanced_features_q == $past(wdata))
    else $error("enhanced features write lost");
  AST_EF_REFUSE: assert property (wr_en && addr == ADDR_ENHANCED_FEATURES &&
    line_control_q != LINE_CONTROL_BANK650 |=> $stable(enhanced_features_q))
    else $error("enhanced features written outside 650 bank");
  AST_STATUS_GATE: assert property (rd_en && addr == ADDR_ADDITIONAL_STATUS && normal &&
    !additional_control_q[AC_STATUS_EN_BIT] |=> rdata_q == 8'h00)
    else $error("status readable while disabled");
  AST_RX_LEVEL_READ: assert property (s_stat_rd(ADDR_RX_FIFO_LEVEL) |=>
    rdata_q == $past(rx_count) && rvalid_q)
    else $error("receive level read wrong");
  AST_TX_LEVEL_READ: assert property (s_stat_rd(ADDR_TX_FIFO_LEVEL) |=>
    rdata_q == $past(tx_count) && rvalid_q)
    else $error("transmit level read wrong");
  AST_FLAGS_WR: assert property (s_status_wr |-> ##2 tx_disable_q == $past(wdata[1:0], 2))
    else $error("status flags not taken from write");
  AST_STATUS_LIVE: assert property (!$past(sys_rst) |->
    additional_status_q[7:2] == $past(live_status))
    else $error("status upper bits not live");
  AST_WIN_RD_GATE: assert property (rd_en && addr == ADDR_INDEXED_WINDOW && normal &&
    !additional_control_q[AC_WINDOW_RD_BIT] |=> rdata_q == 8'h00)
    else $error("window readable while disabled");
  AST_TX_THRESH_WIN: assert property (wr_en && addr == ADDR_INDEXED_WINDOW && normal &&
    scratch_index_q == IDX_TX_IRQ_THRESHOLD |=>
    tx_irq_threshold_q == {1'b0, $past(wdata[6:0])})
    else $error("transmit threshold window write wrong");
endmodule : uera_chk

/* File: testbench/tb.sv */
// Purpose: Directed register tests for the extended register access block
// Assumes: Inputs driven at the falling edge, one idle cycle between accesses
// Notes:   Expected values come from the register map, not the design
`timescale 1ns/1ps
module tb;
  import uera_pkg::*;
  logic       clock       = 1'b0;
  logic       sys_rst     = 1'b1;
  logic [2:0] addr        = 3'h0;
  logic       wr_en       = 1'b0;
  logic       rd_en       = 1'b0;
  logic [7:0] wdata       = 8'h00;
  logic [7:0] rx_count    = 8'h2A;
  logic [7:0] tx_count    = 8'h11;
  logic [5:0] live_status = 6'h2D;
  logic [7:0] rdata_q, line_control_q, enhanced_features_q, flow_low_threshold_q;
  logic [7:0] scratch_index_q, resume_char_one_q, resume_char_two_q, pause_char_one_q;
  logic [7:0] pause_char_two_q, clock_prescaler_q, sample_clock_times_q, clock_select_q;
  logic       rvalid_q, cts_flow_en_q, rts_flow_en_q, special_char_en_q, enhanced_mode_q;
  logic [3:0] inband_mode_q;
  logic [7:0] rx_irq_threshold_q;
  logic [1:0] tx_disable_q;
  logic       tx_trigger_q, rx_trigger_q;
  int         n_errors    = 0;
  int         n_compared  = 0;

  always #5 clock = ~clock;

  uera_regs i_dut (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rx_count(rx_count), .tx_count(tx_count),
    .live_status(live_status), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .line_control_q(line_control_q), .scratch_index_q(scratch_index_q),
    .enhanced_features_q(enhanced_features_q), .cts_flow_en_q(cts_flow_en_q),
    .rts_flow_en_q(rts_flow_en_q), .special_char_en_q(special_char_en_q),
    .enhanced_mode_q(enhanced_mode_q), .inband_mode_q(inband_mode_q),
    .resume_char_one_q(resume_char_one_q), .resume_char_two_q(resume_char_two_q),
    .pause_char_one_q(pause_char_one_q), .pause_char_two_q(pause_char_two_q),
    .additional_control_q(), .clock_prescaler_q(clock_prescaler_q),
    .sample_clock_times_q(sample_clock_times_q), .clock_select_q(clock_select_q),
    .tx_irq_threshold_q(), .rx_irq_threshold_q(rx_irq_threshold_q),
    .flow_low_threshold_q(flow_low_threshold_q), .additional_status_q(),
    .tx_disable_q(tx_disable_q), .tx_trigger_q(tx_trigger_q), .rx_trigger_q(rx_trigger_q));

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Each access leaves one idle cycle so no strobe is driven twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clock);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    chk({7'h00, rvalid_q}, 8'h01, "read valid");
    chk(rdata_q, exp, "read data");
  endtask : rd

  task automatic wwin(input logic [7:0] idx, input logic [7:0] d);
    wr(ADDR_SCRATCH_INDEX, idx);
    wr(ADDR_INDEXED_WINDOW, d);
  endtask : wwin

  task automatic rwin(input logic [7:0] idx, input logic [7:0] exp);
    wr(ADDR_SCRATCH_INDEX, idx);
    rd(ADDR_INDEXED_WINDOW, exp);
  endtask : rwin

  initial
  begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    chk(rx_irq_threshold_q, 8'h01, "rx threshold reset");
    chk(enhanced_features_q, 8'h00, "features reset");
    $display("reset test done");
    wr(ADDR_ENHANCED_FEATURES, 8'h5A);
    wr(ADDR_LINE_CONTROL, LINE_CONTROL_BANK650);
    rd(ADDR_ENHANCED_FEATURES, 8'h00);
    wr(ADDR_ENHANCED_FEATURES, 8'hA5);
    rd(ADDR_ENHANCED_FEATURES, 8'hA5);
    chk({cts_flow_en_q, rts_flow_en_q, special_char_en_q, enhanced_mode_q, inband_mode_q},
      8'hA5, "flow decodes");
    for (int i = 4; i < 8; i++)
      wr(3'(i), 8'(8'h30 + i));
    for (int i = 4; i < 8; i++)
      rd(3'(i), 8'(8'h30 + i));
    chk(resume_char_one_q, 8'h34, "resume char one");
    chk(resume_char_two_q, 8'h35, "resume char two");
    chk(pause_char_one_q, 8'h36, "pause char one");
    chk(pause_char_two_q, 8'h37, "pause char two");
    wr(ADDR_LINE_CONTROL, 8'h03);
    rd(ADDR_ENHANCED_FEATURES, 8'h00);
    $display("650 bank test done");
    wwin(IDX_ADDITIONAL_CONTROL, 8'hC0);
    rwin(IDX_ADDITIONAL_CONTROL, 8'hC0);
    wwin(IDX_CLOCK_PRESCALER, 8'h5A);
    wwin(IDX_SAMPLE_CLOCK_TIMES, 8'h0C);
    wwin(IDX_CLOCK_SELECT, 8'h81);
    wwin(IDX_TX_IRQ_THRESHOLD, 8'hFF);
    wwin(IDX_RX_IRQ_THRESHOLD, 8'h85);
    rd(ADDR_SCRATCH_INDEX, IDX_RX_IRQ_THRESHOLD);
    chk(scratch_index_q, IDX_RX_IRQ_THRESHOLD, "scratch index");
    rwin(IDX_CLOCK_PRESCALER, 8'h5A);
    rwin(IDX_SAMPLE_CLOCK_TIMES, 8'h0C);
    rwin(IDX_CLOCK_SELECT, 8'h81);
    chk(clock_prescaler_q, 8'h5A, "clock prescaler");
    chk(sample_clock_times_q, 8'h0C, "sample clock times");
    chk(clock_select_q, 8'h81, "clock select");
    rwin(IDX_TX_IRQ_THRESHOLD, 8'h7F);
    rwin(IDX_RX_IRQ_THRESHOLD, 8'h05);
    chk(flow_low_threshold_q, 8'h05, "flow low threshold");
    rwin(IDX_FLOW_LOW_THRESHOLD, 8'h05);
    wwin(IDX_ADDITIONAL_CONTROL, 8'hA0);
    rwin(IDX_TX_IRQ_THRESHOLD, 8'h00);
    $display("window test done");
    tx_count = 8'h7F;
    @(negedge clock);
    chk({7'h00, tx_trigger_q}, 8'h01, "tx trigger at limit");
    chk({7'h00, rx_trigger_q}, 8'h01, "rx trigger above limit");
    tx_count = 8'h80;
    @(negedge clock);
    chk({7'h00, tx_trigger_q}, 8'h00, "tx trigger past limit");
    tx_count = 8'h11;
    $display("trigger test done");
    rd(ADDR_RX_FIFO_LEVEL, 8'h2A);
    rd(ADDR_TX_FIFO_LEVEL, 8'h11);
    wr(ADDR_ADDITIONAL_STATUS, 8'hFF);
    rd(ADDR_ADDITIONAL_STATUS, 8'hB7);
    chk({6'h00, tx_disable_q}, 8'h03, "tx disable flags");
    wr(ADDR_ADDITIONAL_STATUS, 8'h02);
    rd(ADDR_ADDITIONAL_STATUS, 8'hB6);
    wwin(IDX_ADDITIONAL_CONTROL, 8'h00);
    rd(ADDR_ADDITIONAL_STATUS, 8'h00);
    rd(ADDR_RX_FIFO_LEVEL, 8'h03);
    rd(ADDR_TX_FIFO_LEVEL, 8'h00);
    $display("status test done");
    results();
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    results();
  end
endmodule : tb

bind uera_regs uera_chk i_chk (.clock(clock), .sys_rst(sys_rst), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rx_count(rx_count), .tx_count(tx_count),
  .live_status(live_status), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
  .line_control_q(line_control_q), .scratch_index_q(scratch_index_q),
  .enhanced_features_q(enhanced_features_q), .cts_flow_en_q(cts_flow_en_q),
  .rts_flow_en_q(rts_flow_en_q), .special_char_en_q(special_char_en_q),
  .enhanced_mode_q(enhanced_mode_q), .inband_mode_q(inband_mode_q),
  .additional_control_q(additional_control_q), .tx_irq_threshold_q(tx_irq_threshold_q),
  .additional_status_q(additional_status_q), .tx_disable_q(tx_disable_q));
